/* File: common/stc_pkg.sv */
// Shared constants and types of the stepper clock select and diagnostic block
package stc_pkg;

	////////////////////////////////////////////////////////////////////////
	// Clock figures
	localparam int CLK_HZ = 10_000_000;
	localparam int OSC_HZ = 12_000_000;
	// Oscillator is faster than the system clock: one tick per cycle
	localparam int OSC_DIV = (CLK_HZ >= OSC_HZ) ? CLK_HZ / OSC_HZ : 1;
	// Fallback timeout in internal oscillator ticks
	localparam int EXT_TIMEOUT = 32;

	////////////////////////////////////////////////////////////////////////
	// Register byte addresses
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_VEL = 8'h04;
	localparam logic [7:0] ADDR_STAT = 8'h08;
	localparam logic [7:0] ADDR_MASK = 8'h0c;
	localparam logic [7:0] ADDR_STATE = 8'h10;

	////////////////////////////////////////////////////////////////////////
	// Field positions and widths
	localparam int CTRL_W = 2;
	localparam int CTRL_IDX_STEP = 0;
	localparam int CTRL_GEN_EN = 1;
	localparam int VEL_W = 24;
	localparam int USTEP_W = 10;
	localparam int STAT_W = 5;
	localparam int ST_OLA = 0;
	localparam int ST_OLB = 1;
	localparam int ST_FAULT = 2;
	localparam int ST_EXT_ON = 3;
	localparam int ST_EXT_OFF = 4;
	localparam int SV_USTEP = 0;
	localparam int SV_FAULT = 10;
	localparam int SV_OLA = 11;
	localparam int SV_OLB = 12;
	localparam int SV_EXT = 13;

	////////////////////////////////////////////////////////////////////////
	// Values after reset
	localparam logic [CTRL_W-1:0] CTRL_RST = 2'h0;
	localparam logic [VEL_W-1:0] VEL_RST = 24'h000000;
	localparam logic [STAT_W-1:0] MASK_RST = 5'h00;
	localparam logic [USTEP_W-1:0] USTEP_RST = 10'h000;

	// Selected timing reference
	typedef enum logic {STC_CLK_INT, STC_CLK_EXT} stc_clk_t;

endpackage

/* File: common/stc_tick_if.sv */
// Timing reference carried from the clock selector to its users
`timescale 1ns/10ps
interface stc_tick_if;
	logic refTick;
	logic extActive;
	logic switchOn;
	logic switchOff;
	modport src (output refTick, output extActive, output switchOn,
		output switchOff);
	modport snk (input refTick, input extActive, input switchOn,
		input switchOff);
endinterface // stc_tick_if

/* File: core/stc_clk_sel.sv */
// Internal oscillator or external clock pin as timing reference
`timescale 1ns/10ps
module stc_clk_sel #(
	parameter int DIV = stc_pkg::OSC_DIV,
	parameter int TIMEOUT = stc_pkg::EXT_TIMEOUT
) (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic extClk,
	stc_tick_if.src tick
);
	typedef struct packed {
		stc_pkg::stc_clk_t mode;
		logic prevPin;
		logic [7:0] divCnt;
		logic [7:0] idle;
		logic refTick;
		logic switchOn;
		logic switchOff;
	} stc_csel_t;

	stc_csel_t s_reg;
	stc_csel_t s_next;
	logic oscTick;
	logic rise;

	generate
		if (DIV < 1 || DIV > 256 || TIMEOUT < 1 || TIMEOUT > 255) begin : g_chk
			$error("stc_clk_sel: DIV or TIMEOUT out of range");
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Pin edges are seen only up to half the system clock rate
	assign oscTick = (s_reg.divCnt == 8'(DIV - 1));
	assign rise = extClk & ~s_reg.prevPin;

	// Source selection and timeout
	always_comb begin
		s_next = s_reg;
		s_next.refTick = 1'b0;
		s_next.switchOn = 1'b0;
		s_next.switchOff = 1'b0;
		s_next.prevPin = extClk;
		s_next.divCnt = oscTick ? 8'h00 : s_reg.divCnt + 8'h01;
		case (s_reg.mode)
			stc_pkg::STC_CLK_INT: begin
				s_next.refTick = oscTick; // R9
				if (rise) begin
					s_next.mode = stc_pkg::STC_CLK_EXT; // R10
					s_next.idle = 8'h00;
					s_next.switchOn = 1'b1;
				end
			end
			default: begin
				s_next.refTick = rise;
				if (rise) begin
					s_next.idle = 8'h00;
				end else if (oscTick) begin
					if (s_reg.idle == 8'(TIMEOUT - 1)) begin
						s_next.mode = stc_pkg::STC_CLK_INT; // R11
						s_next.switchOff = 1'b1;
					end else begin
						s_next.idle = s_reg.idle + 8'h01;
					end
				end
			end
		endcase
	end

	// State register
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign tick.refTick = s_reg.refTick;
	assign tick.extActive = (s_reg.mode == stc_pkg::STC_CLK_EXT);
	assign tick.switchOn = s_reg.switchOn;
	assign tick.switchOff = s_reg.switchOff;

	////////////////////////////////////////////////////////////////////////
	default clocking @(posedge clock); endclocking
	default disable iff (!arst_n);

	a_switch_to_ext: assert property ( // R10
		s_reg.mode == stc_pkg::STC_CLK_INT && rise |=>
		s_reg.mode == stc_pkg::STC_CLK_EXT && s_reg.switchOn)
		else $error("no switch to external clock");
	a_int_ref_tick: assert property ( // R9
		s_reg.mode == stc_pkg::STC_CLK_INT && !rise && oscTick |=>
		s_reg.refTick && s_reg.mode == stc_pkg::STC_CLK_INT)
		else $error("internal tick missing");
	a_timeout_revert: assert property ( // R11
		s_reg.mode == stc_pkg::STC_CLK_EXT && !rise && oscTick &&
		s_reg.idle == 8'(TIMEOUT - 1) |=>
		s_reg.mode == stc_pkg::STC_CLK_INT && s_reg.switchOff)
		else $error("no fallback after timeout");
	a_no_early_revert: assert property ( // R11
		s_reg.mode == stc_pkg::STC_CLK_EXT &&
		s_reg.idle < 8'(TIMEOUT - 1) |=>
		s_reg.mode == stc_pkg::STC_CLK_EXT)
		else $error("fallback before timeout");
endmodule // stc_clk_sel

/* File: core/stc_step_gen.sv */
// Internal step pulse generator and step input merge
`timescale 1ns/10ps
module stc_step_gen #(
	parameter int VW = stc_pkg::VEL_W
) (
	input wire logic clock,
	input wire logic arst_n,
	stc_tick_if.snk tick,
	input wire logic genEnable,
	input wire logic [VW-1:0] velocity,
	input wire logic extStep,
	input wire logic extDir,
	output logic stepPulse,
	output logic stepDir
);
	typedef struct packed {
		logic [VW-1:0] acc;
		logic step;
		logic dir;
	} stc_sgen_t;

	stc_sgen_t s_reg;
	stc_sgen_t s_next;
	logic [VW-1:0] mag;
	logic [VW:0] sum;

	generate
		if (VW < 2) begin : g_chk
			$error("stc_step_gen: velocity too narrow");
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Phase accumulator; pin steps take precedence over generated ones
	assign mag = velocity[VW-1] ? VW'(-velocity) : velocity;
	assign sum = {1'b0, s_reg.acc} + {1'b0, mag};

	always_comb begin
		s_next = s_reg;
		s_next.step = 1'b0;
		if (extStep) begin
			s_next.step = 1'b1;
			s_next.dir = extDir;
		end else if (genEnable && tick.refTick) begin // R12
			s_next.acc = sum[VW-1:0];
			if (sum[VW]) begin
				s_next.step = 1'b1;
				s_next.dir = ~velocity[VW-1];
			end
		end
	end

	// State register
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign stepPulse = s_reg.step;
	assign stepDir = s_reg.dir;

	a_step_on_ref: assert property (@(posedge clock) disable iff (!arst_n)
		s_reg.step |-> $past(extStep) || $past(tick.refTick)) // R12
		else $error("step without timing reference");
endmodule // stc_step_gen

/* File: core/stc_clock_fault_output.sv */
// Clock source select, open-load flags, fault and position marker outputs
//
// Design decisions made here: the register offsets and the plain strobed port.
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////
// Function
// R1: A coil's open-load flag is set whenever its commanded current is missed.
// R2: Open-load flags only inform and never change any driver behaviour.
// R3: The host should judge open-load only after a long one-way move.
// R4: The fault output is active exactly while the driver cannot work.
// R5: By default the marker output shows microstep counter position zero.
// R6: Software selects which function drives the marker output.
// R7: In step mode the marker output toggles once per executed step.
// R8: Reset loads defaults, some of them taken from one-time memory.
// R9: With no clock edge seen the internal oscillator is the reference.
// R10: The first rising edge on the clock pin selects the external clock.
// R11: After 32 oscillator ticks with no pin edge, fall back to internal.
// R12: The selected clock paces every timing function, steps included.
// R13: The host keeps its external clock within the recommended band.
// R14: Fault stays active while a short or overheat holds a bridge off.
module stc_clock_fault_output #(
	parameter int VW = stc_pkg::VEL_W,
	parameter int UW = stc_pkg::USTEP_W
) (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic [7:0] regAddr,
	input wire logic [31:0] regWdata,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [31:0] regRdata,
	input wire logic extClk,
	input wire logic stepIn,
	input wire logic dirIn,
	input wire logic otpIndexStep,
	input wire logic coilAMiss,
	input wire logic coilBMiss,
	input wire logic shortA,
	input wire logic shortB,
	input wire logic overTemp,
	input wire logic underVolt,
	output logic faultOut,
	output logic indexOut,
	output logic irq
);
	typedef struct packed {
		logic [stc_pkg::CTRL_W-1:0] ctrl;
		logic [VW-1:0] vel;
		logic [stc_pkg::STAT_W-1:0] stat;
		logic [stc_pkg::STAT_W-1:0] mask;
		logic [UW-1:0] ustep;
		logic [31:0] rdata;
		logic olA;
		logic olB;
		logic fault;
		logic index;
		logic irq;
		logic otpDone;
	} stc_top_t;

	stc_top_t s_reg;
	stc_top_t s_next;
	stc_tick_if tick ();
	logic stepPulse;
	logic stepDir;
	logic faultCause;
	logic [stc_pkg::STAT_W-1:0] events;
	logic [31:0] stateWord;

	generate
		if (VW < 2 || VW > 32 || UW < 2 || UW > 10) begin : g_chk
			$error("stc_clock_fault_output: width parameter out of range");
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Address match, shared by the write and read paths
	function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
		hit = (a == o);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Timing reference selection
	stc_clk_sel u_clk_sel (
		.clock(clock),
		.arst_n(arst_n),
		.extClk(extClk),
		.tick(tick)
	);

	// Steps from the pin or from the generator paced by the reference
	stc_step_gen #(
		.VW(VW)
	) u_step_gen (
		.clock(clock),
		.arst_n(arst_n),
		.tick(tick),
		.genEnable(s_reg.ctrl[stc_pkg::CTRL_GEN_EN]),
		.velocity(s_reg.vel),
		.extStep(stepIn),
		.extDir(dirIn),
		.stepPulse(stepPulse),
		.stepDir(stepDir)
	);

	////////////////////////////////////////////////////////////////////////
	// Any condition that keeps a bridge off counts as a fault
	assign faultCause = shortA | shortB | overTemp | underVolt; // R4

	// Event sources for the sticky status bits
	always_comb begin
		events = '0;
		events[stc_pkg::ST_OLA] = s_reg.olA;
		events[stc_pkg::ST_OLB] = s_reg.olB;
		events[stc_pkg::ST_FAULT] = s_reg.fault;
		events[stc_pkg::ST_EXT_ON] = tick.switchOn;
		events[stc_pkg::ST_EXT_OFF] = tick.switchOff;
	end

	// Live state word, upper bits read as zero
	always_comb begin
		stateWord = '0;
		stateWord[stc_pkg::SV_USTEP +: UW] = s_reg.ustep;
		stateWord[stc_pkg::SV_FAULT] = s_reg.fault;
		stateWord[stc_pkg::SV_OLA] = s_reg.olA;
		stateWord[stc_pkg::SV_OLB] = s_reg.olB;
		stateWord[stc_pkg::SV_EXT] = tick.extActive;
	end

	////////////////////////////////////////////////////////////////////////
	// Register access, diagnostics and marker output
	always_comb begin
		s_next = s_reg;
		s_next.rdata = '0;
		// One-time memory default caught on the first edge after reset
		if (!s_reg.otpDone) begin
			s_next.ctrl[stc_pkg::CTRL_IDX_STEP] = otpIndexStep; // R8
			s_next.otpDone = 1'b1;
		end
		// Writes; status clears are write-one
		if (regWrite) begin
			if (hit(regAddr, stc_pkg::ADDR_CTRL)) begin
				s_next.ctrl = regWdata[stc_pkg::CTRL_W-1:0]; // R6
			end else if (hit(regAddr, stc_pkg::ADDR_VEL)) begin
				s_next.vel = regWdata[VW-1:0];
			end else if (hit(regAddr, stc_pkg::ADDR_STAT)) begin
				s_next.stat = s_reg.stat & ~regWdata[stc_pkg::STAT_W-1:0];
			end else if (hit(regAddr, stc_pkg::ADDR_MASK)) begin
				s_next.mask = regWdata[stc_pkg::STAT_W-1:0];
			end
		end
		// Reads answer one cycle later; unmapped reads give zero
		if (regRead) begin
			if (hit(regAddr, stc_pkg::ADDR_CTRL)) begin
				s_next.rdata = 32'(s_reg.ctrl);
			end else if (hit(regAddr, stc_pkg::ADDR_VEL)) begin
				s_next.rdata = 32'(s_reg.vel);
			end else if (hit(regAddr, stc_pkg::ADDR_STAT)) begin
				s_next.rdata = 32'(s_reg.stat);
			end else if (hit(regAddr, stc_pkg::ADDR_MASK)) begin
				s_next.rdata = 32'(s_reg.mask);
			end else if (hit(regAddr, stc_pkg::ADDR_STATE)) begin
				s_next.rdata = stateWord;
			end
		end
		// New events win over a clear in the same cycle
		s_next.stat = s_next.stat | events;
		// Flags track the current check; the open-load ones feed only the status bits and state word
		s_next.olA = coilAMiss; // R1 R2
		s_next.olB = coilBMiss; // R1
		s_next.fault = faultCause; // R14
		// Counter wraps both ways
		if (stepPulse) begin
			s_next.ustep = stepDir ? s_reg.ustep + UW'(1) :
				s_reg.ustep - UW'(1);
		end
		// Marker output: step toggle or zero position
		if (s_next.ctrl[stc_pkg::CTRL_IDX_STEP]) begin
			if (stepPulse) begin
				s_next.index = ~s_reg.index; // R7
			end
		end else begin
			s_next.index = (s_next.ustep == '0); // R5
		end
		s_next.irq = |(s_next.stat & s_next.mask);
	end

	// State register; control defaults until the memory load
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			s_reg <= '0;
			s_reg.ctrl <= stc_pkg::CTRL_RST; // R8
			s_reg.vel <= stc_pkg::VEL_RST;
			s_reg.mask <= stc_pkg::MASK_RST;
			s_reg.ustep <= stc_pkg::USTEP_RST;
			s_reg.index <= 1'b1;
		end else begin
			s_reg <= s_next;
		end
	end

	assign regRdata = s_reg.rdata;
	assign faultOut = s_reg.fault;
	assign indexOut = s_reg.index;
	assign irq = s_reg.irq;

	////////////////////////////////////////////////////////////////////////
	default clocking @(posedge clock); endclocking
	default disable iff (!arst_n);

	// Open-load flags are registered copies of the miss inputs
	a_openload_flag: assert property ( // R1
		coilAMiss |=> s_reg.olA)
		else $error("coil A open-load flag not set");

	a_openload_b: assert property ( // R1
		coilBMiss |=> s_reg.olB)
		else $error("coil B open-load flag not set");

	a_openload_clear: assert property ( // R1
		!coilAMiss && !coilBMiss |=> !s_reg.olA && !s_reg.olB)
		else $error("open-load flag stuck");

	a_ol_no_effect: assert property ( // R2
		(coilAMiss || coilBMiss) && !faultCause |=> !faultOut)
		else $error("open-load changed fault output");

	a_ol_no_config: assert property ( // R2
		(coilAMiss || coilBMiss) && s_reg.otpDone && !regWrite |=>
		$stable(s_reg.ctrl) && $stable(s_reg.vel))
		else $error("open-load changed configuration");

	// Fault output follows its causes one cycle late, no latching
	a_fault_active: assert property ( // R4
		faultCause |=> faultOut)
		else $error("fault output not active");

	a_fault_quiet: assert property ( // R4
		!faultCause |=> !faultOut)
		else $error("fault output active without cause");

	a_fault_release: assert property ( // R14
		faultCause ##1 !faultCause |=> !faultOut)
		else $error("fault output not released");

	// Marker output and microstep counter
	a_index_zero: assert property ( // R5
		!s_reg.ctrl[stc_pkg::CTRL_IDX_STEP] && s_reg.otpDone &&
		!regWrite && stepPulse && !stepDir &&
		s_reg.ustep == UW'(1) |=> indexOut)
		else $error("marker missed zero position");

	a_index_level: assert property ( // R5
		s_reg.otpDone && !s_reg.ctrl[stc_pkg::CTRL_IDX_STEP] &&
		!regWrite |=> indexOut == (s_reg.ustep == '0))
		else $error("marker disagrees with counter");

	a_index_hold: assert property ( // R5 R7
		s_reg.otpDone && !regWrite && !stepPulse |=> $stable(indexOut))
		else $error("marker moved without a step");

	a_index_toggle: assert property ( // R7
		s_reg.ctrl[stc_pkg::CTRL_IDX_STEP] && s_reg.otpDone && !regWrite &&
		stepPulse |=> indexOut != $past(indexOut))
		else $error("marker did not toggle");

	a_count_up: assert property ( // R5
		stepPulse && stepDir |=>
		s_reg.ustep == $past(s_reg.ustep) + UW'(1))
		else $error("counter did not count up");

	a_count_down: assert property ( // R5
		stepPulse && !stepDir |=>
		s_reg.ustep == $past(s_reg.ustep) - UW'(1))
		else $error("counter did not count down");

	a_count_hold: assert property ( // R5
		!stepPulse |=> $stable(s_reg.ustep))
		else $error("counter moved without a step");

	// Configuration: writes land the next cycle, default loaded once
	a_ctrl_write: assert property ( // R6
		s_reg.otpDone && regWrite && hit(regAddr, stc_pkg::ADDR_CTRL) |=>
		s_reg.ctrl == $past(regWdata[stc_pkg::CTRL_W-1:0]))
		else $error("control write lost");

	a_otp_load: assert property ( // R8
		!s_reg.otpDone && !regWrite |=>
		s_reg.ctrl[stc_pkg::CTRL_IDX_STEP] == $past(otpIndexStep) &&
		s_reg.otpDone)
		else $error("one-time default not loaded");

	a_vel_write: assert property (
		regWrite && hit(regAddr, stc_pkg::ADDR_VEL) |=>
		s_reg.vel == $past(regWdata[VW-1:0]))
		else $error("velocity write lost");

	a_mask_write: assert property (
		regWrite && hit(regAddr, stc_pkg::ADDR_MASK) |=>
		s_reg.mask == $past(regWdata[stc_pkg::STAT_W-1:0]))
		else $error("mask write lost");

	// Sticky status: no bit drops without a clear, events beat a clear
	a_stat_sticky: assert property (
		!(regWrite && hit(regAddr, stc_pkg::ADDR_STAT)) |=>
		(s_reg.stat & $past(s_reg.stat)) == $past(s_reg.stat))
		else $error("status bit lost");

	a_stat_set_wins: assert property ( // R4
		s_reg.fault |=> s_reg.stat[stc_pkg::ST_FAULT])
		else $error("fault event lost to a clear");

	a_stat_clear: assert property (
		regWrite && hit(regAddr, stc_pkg::ADDR_STAT) && events == '0 &&
		regWdata[stc_pkg::STAT_W-1:0] == '1 |=> s_reg.stat == '0)
		else $error("status clear failed");

	a_ext_on_flag: assert property ( // R10
		tick.switchOn |=> s_reg.stat[stc_pkg::ST_EXT_ON])
		else $error("switch to external not flagged");

	a_ext_off_flag: assert property ( // R11
		tick.switchOff |=> s_reg.stat[stc_pkg::ST_EXT_OFF])
		else $error("fallback to internal not flagged");

	a_irq_level: assert property (
		irq == |(s_reg.stat & s_reg.mask))
		else $error("interrupt level wrong");

	// Read data stand one cycle only
	a_read_answer: assert property (
		regRead && hit(regAddr, stc_pkg::ADDR_MASK) && !regWrite |=>
		regRdata == 32'($past(s_reg.mask)) ##1
		(regRdata == '0 || $past(regRead)))
		else $error("read answer wrong");

	a_read_idle: assert property (
		!regRead |=> regRdata == '0)
		else $error("read data outside its cycle");

	a_read_ctrl: assert property ( // R6
		regRead && hit(regAddr, stc_pkg::ADDR_CTRL) |=>
		regRdata == 32'($past(s_reg.ctrl)))
		else $error("control read wrong");

	a_read_state: assert property ( // R5
		regRead && hit(regAddr, stc_pkg::ADDR_STATE) |=>
		regRdata[UW-1:0] == $past(s_reg.ustep) &&
		regRdata[stc_pkg::SV_FAULT] == $past(s_reg.fault) &&
		regRdata[stc_pkg::SV_EXT] == $past(tick.extActive))
		else $error("state word wrong");

	a_read_unmapped: assert property (
		regRead && !hit(regAddr, stc_pkg::ADDR_CTRL) &&
		!hit(regAddr, stc_pkg::ADDR_VEL) &&
		!hit(regAddr, stc_pkg::ADDR_STAT) &&
		!hit(regAddr, stc_pkg::ADDR_MASK) &&
		!hit(regAddr, stc_pkg::ADDR_STATE) |=>
		regRdata == '0)
		else $error("unmapped read not zero");
endmodule // stc_clock_fault_output

/* File: bench/stc_host_model.sv */
// Host side clock source for the stepper clock select block
`timescale 1ns/10ps
module stc_host_model #(
	parameter int HALF = 4
) (
	input wire logic clock,
	input wire logic run,
	output logic extClk
);
	int phase = 0;
	initial extClk = 1'b0;
	// Clock bursts only; the pin rests low between bursts like a grounded pin.
	// Rate is scaled far below the system clock, else edges go unseen.
	always @(posedge clock) begin
		if (!run) begin
			phase <= 0;
			extClk <= 1'b0;
		end else if (phase == HALF - 1) begin
			phase <= 0;
			extClk <= ~extClk;
		end else begin
			phase <= phase + 1;
		end
	end
endmodule // stc_host_model

/* File: bench/stc_clock_fault_output_test.sv */
// Self-checking bench of the clock select and diagnostic block
`timescale 1ns/10ps
module stc_clock_fault_output_test;
	logic clock = 1'b0;
	logic arst_n = 1'b0;
	logic [7:0] regAddr = 8'h00;
	logic [31:0] regWdata = 32'h00000000;
	logic regWrite = 1'b0;
	logic regRead = 1'b0;
	logic stepIn = 1'b0;
	logic dirIn = 1'b0;
	logic otp = 1'b0;
	logic missA = 1'b0;
	logic missB = 1'b0;
	logic run = 1'b0;
	logic [3:0] cause = 4'h0;
	logic [31:0] regRdata;
	logic [31:0] rdv;
	logic faultOut;
	logic indexOut;
	logic irq;
	logic extClk;
	int miscompares = 0;
	int compares = 0;
	int cnt = 0;
	int idx = 1;
	int mode = 0;
	int i;
	int j;

	////////////////////////////////////////////////////////////////////////
	// Clock, device and host
	always #50 clock = ~clock;

	stc_clock_fault_output i_dut (.clock(clock), .arst_n(arst_n),
		.regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
		.regRead(regRead), .regRdata(regRdata), .extClk(extClk),
		.stepIn(stepIn), .dirIn(dirIn), .otpIndexStep(otp),
		.coilAMiss(missA), .coilBMiss(missB), .shortA(cause[0]),
		.shortB(cause[1]), .overTemp(cause[2]), .underVolt(cause[3]),
		.faultOut(faultOut), .indexOut(indexOut), .irq(irq));

	stc_host_model i_host (.clock(clock), .run(run), .extClk(extClk));

	////////////////////////////////////////////////////////////////////////
	// Checks and bus cycles
	task automatic end_sim;
		$display("Compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic chkReg(string nm, logic [31:0] e, logic [31:0] g);
		compares++;
		if (g !== e) begin
			miscompares++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic chkPin(string nm, logic e, logic g);
		compares++;
		if (g !== e) begin
			miscompares++;
			$display("Error %s expected %b seen %b", nm, e, g);
		end
	endtask

	// Range compare: generator phase at start is not known to the bench
	task automatic chkNear(string nm, logic [9:0] lo, logic [9:0] hi,
		logic [9:0] g);
		compares++;
		if ((g >= lo && g <= hi) !== 1'b1) begin
			miscompares++;
			$display("Error %s expected %0d..%0d seen %0d", nm, lo, hi, g);
		end
	endtask

	task automatic wr(logic [7:0] a, logic [31:0] d);
		@(posedge clock);
		regWrite <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge clock);
		regWrite <= 1'b0;
	endtask

	task automatic rd(logic [7:0] a);
		@(posedge clock);
		regRead <= 1'b1;
		regAddr <= a;
		@(posedge clock);
		regRead <= 1'b0;
		#1 rdv = regRdata;
	endtask

	task automatic rst(logic o);
		@(posedge clock);
		otp <= o;
		arst_n <= 1'b0;
		repeat (3) @(posedge clock);
		#1 chkPin("faultOut", 1'b0, faultOut);
		chkPin("indexOut", 1'b1, indexOut);
		chkPin("irq", 1'b0, irq);
		@(posedge clock);
		arst_n <= 1'b1;
		cnt = 0;
		idx = 1;
	endtask

	// One step, model updated, marker looked at once it has settled
	task automatic step(logic d);
		@(posedge clock);
		stepIn <= 1'b1;
		dirIn <= d;
		@(posedge clock);
		stepIn <= 1'b0;
		cnt = (cnt + (d ? 1 : 1023)) % 1024;
		idx = mode ? !idx : (cnt == 0);
		repeat (2) @(posedge clock);
		#1 chkPin("indexOut", idx[0], indexOut);
	endtask

	// Negative velocity counts down, so the step count is taken both ways
	task automatic gen(logic [31:0] v, logic [9:0] lo, logic [9:0] hi);
		logic [9:0] b;
		logic [9:0] n;
		rd(stc_pkg::ADDR_STATE);
		b = rdv[9:0];
		wr(stc_pkg::ADDR_VEL, v);
		rd(stc_pkg::ADDR_VEL);
		chkReg("vel", v, rdv);
		wr(stc_pkg::ADDR_CTRL, 32'h00000002);
		repeat (64) @(posedge clock);
		wr(stc_pkg::ADDR_CTRL, 32'h00000000);
		repeat (4) @(posedge clock);
		rd(stc_pkg::ADDR_STATE);
		n = v[23] ? b - rdv[9:0] : rdv[9:0] - b;
		chkNear("steps", lo, hi, n);
	endtask

	////////////////////////////////////////////////////////////////////////
	// Main sequence; the watchdog covers a hang in any wait
	initial begin
		repeat (20000) @(posedge clock);
		miscompares++;
		end_sim;
	end

	initial begin
		void'($urandom(48883));
		for (i = 0; i < 2; i++) begin
			rst(i[0]);
			rd(stc_pkg::ADDR_CTRL);
			chkReg("ctrl", 32'(i[0]), rdv);
			rd(stc_pkg::ADDR_MASK);
			chkReg("mask", 32'h0, rdv);
			rd(stc_pkg::ADDR_VEL);
			chkReg("vel", 32'h0, rdv);
			rd(stc_pkg::ADDR_STATE);
			chkReg("state", 32'h0, rdv);
			rd(8'h20);
			chkReg("unmapped", 32'h0, rdv);
		end
		// Step mode comes from the one-time default of the last reset
		mode = 1;
		for (j = 0; j < 12; j++) step(1'($urandom));
		wr(stc_pkg::ADDR_CTRL, 32'h0);
		mode = 0;
		for (j = 0; j < 16; j++) step(1'($urandom));
		while (cnt != 0) step(cnt >= 512);
		rd(stc_pkg::ADDR_STATE);
		chkReg("state", 32'(cnt), rdv);
		for (j = 0; j < 4; j++) begin
			@(posedge clock);
			cause <= 4'h1 << j;
			repeat (2) @(posedge clock);
			#1 chkPin("faultOut", 1'b1, faultOut);
			rd(stc_pkg::ADDR_STATE);
			chkReg("state", 32'(cnt) | 32'h400, rdv);
			@(posedge clock);
			cause <= 4'h0;
			repeat (2) @(posedge clock);
			#1 chkPin("faultOut", 1'b0, faultOut);
		end
		for (j = 0; j < 2; j++) begin
			@(posedge clock);
			{missB, missA} <= 2'h1 << j;
			repeat (2) @(posedge clock);
			#1 chkPin("faultOut", 1'b0, faultOut);
			rd(stc_pkg::ADDR_STATE);
			chkReg("state", 32'(cnt) | (32'h800 << j), rdv);
			@(posedge clock);
			{missB, missA} <= 2'h0;
			repeat (3) @(posedge clock);
		end
		// Interrupt: masked event, unmasked event, sticky until cleared
		wr(stc_pkg::ADDR_STAT, 32'h1f);
		rd(stc_pkg::ADDR_STAT);
		chkReg("status", 32'h0, rdv);
		wr(stc_pkg::ADDR_MASK, 32'h4);
		@(posedge clock);
		missA <= 1'b1;
		repeat (3) @(posedge clock);
		#1 chkPin("irq", 1'b0, irq);
		rd(stc_pkg::ADDR_STAT);
		chkReg("status", 32'h1, rdv);
		@(posedge clock);
		missA <= 1'b0;
		cause <= 4'h1;
		repeat (3) @(posedge clock);
		#1 chkPin("irq", 1'b1, irq);
		@(posedge clock);
		cause <= 4'h0;
		repeat (3) @(posedge clock);
		#1 chkPin("irq", 1'b1, irq);
		wr(stc_pkg::ADDR_STAT, 32'h5);
		repeat (2) @(posedge clock);
		#1 chkPin("irq", 1'b0, irq);
		rd(stc_pkg::ADDR_MASK);
		chkReg("mask", 32'h4, rdv);
		// Clock source: switch on first edge, fall back after silence
		@(posedge clock);
		run <= 1'b1;
		repeat (20) @(posedge clock);
		rd(stc_pkg::ADDR_STATE);
		chkReg("extOn", 32'h2000, rdv & 32'h2000);
		rd(stc_pkg::ADDR_STAT);
		chkReg("status", 32'h8, rdv);
		gen(32'h00400000, 10'd1, 10'd3);
		rd(stc_pkg::ADDR_STATE);
		chkReg("extOn", 32'h2000, rdv & 32'h2000);
		@(posedge clock);
		run <= 1'b0;
		repeat (40) @(posedge clock);
		rd(stc_pkg::ADDR_STATE);
		chkReg("extOff", 32'h0, rdv & 32'h2000);
		rd(stc_pkg::ADDR_STAT);
		chkReg("status", 32'h18, rdv);
		gen(32'h00c00000, 10'd14, 10'd18);
		end_sim;
	end
endmodule // stc_clock_fault_output_test
